// ---- core/flash_regs_pkg.sv ----
/*
 * Constants shared by the flash disk host control register bank:
 * window offsets, field positions, reset values and mode codes.
 * Assumes byte offsets inside the 8 KB host memory window.
 */
package flash_regs_pkg;

	// Widths of the host window
	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;

	// Register offsets inside the window
	localparam logic [12:0] OFS_IDENT_LOW    = 13'h1000;
	localparam logic [12:0] OFS_SCRATCH      = 13'h1004;
	localparam logic [12:0] OFS_SWAP_CTRL    = 13'h1008;
	localparam logic [12:0] OFS_OP_CTRL      = 13'h100c;
	localparam logic [12:0] OFS_READ_PTR     = 13'h101a;
	localparam logic [12:0] OFS_NOP          = 13'h103e;
	localparam logic [12:0] OFS_CONFIRM      = 13'h1072;
	localparam logic [12:0] OFS_IDENT_HIGH   = 13'h1074;

	// Boot block sections: below and at or above these limits
	localparam logic [12:0] BOOT_LOW_END     = 13'h0800;
	localparam logic [12:0] BOOT_HIGH_START  = 13'h1800;

	// Read pointer fields
	localparam int PTR_INC_BIT      = 15;
	localparam int PTR_ONE_BYTE_BIT = 14;
	localparam int PTR_ADDR_MSB     = 12;

	// Byte swap fields
	localparam int SWAP_LOW_BIT  = 0;
	localparam int SWAP_HIGH_BIT = 8;

	// Operating control fields
	localparam int MODE_LSB        = 0;
	localparam int MODE_MSB        = 1;
	localparam int MODE_WREN_BIT   = 2;
	localparam int BOOT_FLAG_BIT   = 3;
	localparam int RESET_FLAG_BIT  = 4;

	// Mode codes
	localparam logic [1:0] MODE_RESET  = 2'h0;
	localparam logic [1:0] MODE_NORMAL = 2'h1;
	localparam logic [1:0] MODE_DPD    = 2'h2;

	// Values after reset
	localparam logic [7:0]  SCRATCH_RST   = 8'h00;
	localparam logic [15:0] SWAP_RST      = 16'h0000;
	localparam logic [15:0] PTR_RST       = 16'h0000;
	localparam logic [7:0]  CONTROL_RST   = 8'h10;
	localparam logic [15:0] READ_ZERO     = 16'h0000;
	localparam logic [5:0]  PIN_IDLE      = 6'h3f;

	// Pointer steps
	localparam logic [12:0] STEP_BYTE = 13'h0001;
	localparam logic [12:0] STEP_WORD = 13'h0002;

	// Host bus cycle tracker, one-hot
	typedef enum logic [2:0] {
		CYC_IDLE  = 3'b001,
		CYC_READ  = 3'b010,
		CYC_WRITE = 3'b100
	} cycle_t;

endpackage

// ---- core/flash_regs.sv ----
/*
 * Host control register bank of a NAND flash disk device: read pointer,
 * no-operation register, identification, scratch, byte swap and the
 * guarded operating control register with its sticky cause flags.
 * Assumes an asynchronous host bus (chip select, read and write strobes,
 * address and data) whose pins are synchronised here; the data port
 * access pulse and reset causes other than pins come from same-clock logic.
 */
//
// Functional notes
// - Read pointer holds a 13-bit register address for the next read.
// - Increment bit set advances pointer per read: byte in 8-bit, word in 16-bit.
// - Increment bit clear leaves the pointer unchanged.
// - Host sets single-byte bit; device clears it after the data port access.
// - No-operation register accesses change nothing; write only, no reset value.
// - Two read-only identification registers return fixed constants.
// - Scratch register stores and returns host data, resets to zero.
// - Both swap bits set exchange data bytes on 16-bit transfers.
// - Confirm register is write only; reads do not return control contents.
// - Mode field: 00 reset, 01 normal, 10 deep power-down.
// - Mode changes need the write-enable bit; it always reads zero.
// - Boot detector entry to reset sets boot flag; host clears by writing one.
// - Reset pin or voltage detector sets reset flag; cleared by one; resets to one.
// - Every read returns zero while in reset mode.
// - Interface configuration indication follows the configuration pin; no register reads it back, the pin only sets word steps and swap.
module flash_regs
	import flash_regs_pkg::*;
#(
	parameter logic [15:0] IDENT_LOW_VAL  = 16'h1234, // Arbitrary value
	parameter logic [15:0] IDENT_HIGH_VAL = 16'hedcb  // Arbitrary value
)
(
	// Clock, reset, enable
	input  wire logic                         ref_clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic                         clk_en_i,
	// Host bus pins
	input  wire logic                         host_cs_n_i,
	input  wire logic                         host_rd_n_i,
	input  wire logic                         host_wr_n_i,
	input  wire logic [flash_regs_pkg::ADDR_W-1:0] host_addr_i,
	input  wire logic [flash_regs_pkg::DATA_W-1:0] host_data_i,
	output logic      [flash_regs_pkg::DATA_W-1:0] host_data_o,
	output logic                              host_data_oe_o,
	// Reset causes and configuration pins
	input  wire logic                         external_reset_in_n_i,
	input  wire logic                         voltage_fault_i,
	input  wire logic                         boot_detect_i,
	input  wire logic                         interface_cfg_i,
	// Flash data path side
	input  wire logic                         data_port_access_i,
	output logic      [flash_regs_pkg::ADDR_W-1:0] read_ptr_o,
	output logic                              one_byte_o,
	output logic                              swap_active_o,
	output logic      [1:0]                   mode_o
);
	import flash_regs_pkg::*;

	// Two-flop synchronisers for all pin inputs
	logic [ADDR_W-1:0] addr_m_q, addr_q;
	logic [DATA_W-1:0] din_m_q, din_q;
	logic [5:0]        pin_m_q, pin_q;
	logic [ADDR_W-1:0] cyc_addr_q;
	cycle_t            cyc_q;
	logic [1:0]        mode_q;
	logic              boot_flag_q, reset_flag_q;
	logic [7:0]        scratch_q;
	logic [15:0]       swap_q;
	logic              inc_q, one_byte_q;
	logic [ADDR_W-1:0] ptr_q;
	logic [7:0]        pend_q;
	logic              pend_valid_q;
	logic              cs_s, rd_s, wr_s, rst_pin_s, vfault_s, boot_s, cfg_s;
	logic              rd_start, rd_end, wr_end, wide, swap_en, in_reset;
	logic              confirm_ok, ctrl_wr, reset_cause, boot_cause;
	logic [15:0]       wdata, rdata, rdata_raw;

	// Boot block sections of the window
	function automatic logic is_boot_block(input logic [ADDR_W-1:0] a);
		return (a < BOOT_LOW_END) || (a >= BOOT_HIGH_START);
	endfunction

	// Write decode at the captured cycle address
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
		return a == ofs;
	endfunction

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			addr_m_q <= '0;
			addr_q   <= '0;
			din_m_q  <= '0;
			din_q    <= '0;
			pin_m_q  <= PIN_IDLE;
			pin_q    <= PIN_IDLE;
		end
		else if (clk_en_i)
		begin
			addr_m_q <= host_addr_i;
			addr_q   <= addr_m_q;
			din_m_q  <= host_data_i;
			din_q    <= din_m_q;
			pin_m_q  <= {host_cs_n_i, host_rd_n_i, host_wr_n_i, external_reset_in_n_i,
				~voltage_fault_i, ~boot_detect_i};
			pin_q    <= pin_m_q;
		end
	end

	// Configuration pin kept as a separate synchronised level
	logic cfg_m_q, cfg_q;
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			cfg_m_q <= 1'b0;
			cfg_q   <= 1'b0;
		end
		else if (clk_en_i)
		begin
			cfg_m_q <= interface_cfg_i;
			cfg_q   <= cfg_m_q;
		end
	end

	// Synchronised levels, active high
	assign cs_s      = ~pin_q[5];
	assign rd_s      = cs_s & ~pin_q[4];
	assign wr_s      = cs_s & ~pin_q[3];
	assign rst_pin_s = ~pin_q[2];
	assign vfault_s  = ~pin_q[1];
	assign boot_s    = ~pin_q[0];
	assign cfg_s     = cfg_q;
	assign wide      = cfg_s;
	assign in_reset  = (mode_q == MODE_RESET);
	assign swap_en   = wide & swap_q[SWAP_LOW_BIT] & swap_q[SWAP_HIGH_BIT];
	assign wdata     = swap_en ? {din_q[7:0], din_q[15:8]} : din_q;

	// Strobe edges seen by the cycle tracker
	assign rd_start = (cyc_q == CYC_IDLE) & rd_s;
	assign rd_end   = (cyc_q == CYC_READ) & ~rd_s;
	assign wr_end   = (cyc_q == CYC_WRITE) & ~wr_s;

	// Host bus cycle tracker
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			cyc_q      <= CYC_IDLE;
			cyc_addr_q <= '0;
		end
		else if (clk_en_i)
		begin
			case (cyc_q)
				CYC_IDLE:
				begin
					cyc_addr_q <= addr_q;
					if (rd_s)
						cyc_q <= CYC_READ;
					else if (wr_s)
						cyc_q <= CYC_WRITE;
				end
				CYC_READ:
					if (!rd_s)
						cyc_q <= CYC_IDLE;
				CYC_WRITE:
					if (!wr_s)
						cyc_q <= CYC_IDLE;
				default:
					cyc_q <= CYC_IDLE;
			endcase
		end
	end

	// Read data multiplexer
	always_comb
	begin
		rdata_raw = READ_ZERO;
		case (addr_q)
			OFS_IDENT_LOW:  rdata_raw = IDENT_LOW_VAL;
			OFS_IDENT_HIGH: rdata_raw = IDENT_HIGH_VAL;
			OFS_SCRATCH:    rdata_raw = {8'h00, scratch_q};
			OFS_SWAP_CTRL:  rdata_raw = swap_q;
			OFS_OP_CTRL:    rdata_raw = {8'h00, 3'h0, reset_flag_q, boot_flag_q,
				1'b0, mode_q};
			OFS_READ_PTR:   rdata_raw = {inc_q, one_byte_q, 1'b0, ptr_q};
			default:        rdata_raw = READ_ZERO;
		endcase
		rdata = in_reset ? READ_ZERO : rdata_raw;
	end

	// Host data output, driven during a read cycle
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			host_data_o    <= '0;
			host_data_oe_o <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (rd_start)
			begin
				host_data_o    <= swap_en ? {rdata[7:0], rdata[15:8]} : rdata;
				host_data_oe_o <= 1'b1;
			end
			else if (rd_end)
				host_data_oe_o <= 1'b0;
		end
	end

	// Reset causes and confirmed control write
	assign reset_cause = rst_pin_s | vfault_s;
	assign boot_cause  = boot_s;
	assign ctrl_wr     = wr_end & hit(cyc_addr_q, OFS_CONFIRM) & pend_valid_q;
	assign confirm_ok  = ctrl_wr & (wdata[7:0] == ~pend_q);

	// Pending control value waiting for its complement
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			pend_q       <= '0;
			pend_valid_q <= 1'b0;
		end
		else if (clk_en_i)
		begin
			if (wr_end && hit(cyc_addr_q, OFS_OP_CTRL))
			begin
				pend_q       <= wdata[7:0];
				pend_valid_q <= 1'b1;
			end
			else if (wr_end || (rd_end && !is_boot_block(cyc_addr_q)))
				pend_valid_q <= 1'b0;
		end
	end

	// Mode and sticky cause flags
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			mode_q       <= CONTROL_RST[MODE_MSB:MODE_LSB];
			boot_flag_q  <= CONTROL_RST[BOOT_FLAG_BIT];
			reset_flag_q <= CONTROL_RST[RESET_FLAG_BIT];
		end
		else if (clk_en_i)
		begin
			if (reset_cause || boot_cause)
				mode_q <= MODE_RESET;
			else if (confirm_ok && pend_q[MODE_WREN_BIT]
				&& (pend_q[MODE_MSB:MODE_LSB] != 2'h3))
				mode_q <= pend_q[MODE_MSB:MODE_LSB];
			if (boot_cause)
				boot_flag_q <= 1'b1;
			else if (confirm_ok && pend_q[BOOT_FLAG_BIT])
				boot_flag_q <= 1'b0;
			if (reset_cause)
				reset_flag_q <= 1'b1;
			else if (confirm_ok && pend_q[RESET_FLAG_BIT])
				reset_flag_q <= 1'b0;
		end
	end

	// Scratch and byte swap registers, held at reset values in reset mode
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i || (clk_en_i && in_reset))
		begin
			scratch_q <= SCRATCH_RST;
			swap_q    <= SWAP_RST;
		end
		else if (clk_en_i && wr_end)
		begin
			if (hit(cyc_addr_q, OFS_SCRATCH))
				scratch_q <= wdata[7:0];
			if (hit(cyc_addr_q, OFS_SWAP_CTRL))
			begin
				swap_q                <= SWAP_RST;
				swap_q[SWAP_LOW_BIT]  <= wdata[SWAP_LOW_BIT];
				swap_q[SWAP_HIGH_BIT] <= wdata[SWAP_HIGH_BIT];
			end
		end
	end

	// Read pointer with increment and single-byte control
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i || (clk_en_i && in_reset))
		begin
			inc_q      <= PTR_RST[PTR_INC_BIT];
			one_byte_q <= PTR_RST[PTR_ONE_BYTE_BIT];
			ptr_q      <= PTR_RST[PTR_ADDR_MSB:0];
		end
		else if (clk_en_i)
		begin
			if (wr_end && hit(cyc_addr_q, OFS_READ_PTR))
			begin
				inc_q      <= wdata[PTR_INC_BIT];
				one_byte_q <= wdata[PTR_ONE_BYTE_BIT];
				ptr_q      <= wdata[PTR_ADDR_MSB:0];
			end
			else
			begin
				if (data_port_access_i)
					one_byte_q <= 1'b0;
				if (rd_end && inc_q)
					ptr_q <= ptr_q + (wide ? STEP_WORD : STEP_BYTE);
			end
		end
	end

	// Outputs toward the flash data path
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			read_ptr_o    <= '0;
			one_byte_o    <= 1'b0;
			swap_active_o <= 1'b0;
			mode_o        <= MODE_RESET;
		end
		else if (clk_en_i)
		begin
			read_ptr_o    <= ptr_q;
			one_byte_o    <= one_byte_q;
			swap_active_o <= swap_en;
			mode_o        <= mode_q;
		end
	end

endmodule

// ---- tb/flash_regs_assertions.sv ----
/*
 * Port checker for the flash register bank, bound to flash_regs.
 * Assumes clock enable drops only while cause and configuration pins rest.
 */
module flash_regs_assertions
(
	// Clock and reset
	input wire logic	ref_clk_i,
	input wire logic	rst_n_i,
	// Host bus
	input wire logic	host_rd_n_i,
	input wire logic	host_wr_n_i,
	input wire logic [15:0]	host_data_o,
	input wire logic	host_data_oe_o,
	// Causes and pins
	input wire logic	external_reset_in_n_i,
	input wire logic	voltage_fault_i,
	input wire logic	boot_detect_i,
	input wire logic	interface_cfg_i,
	input wire logic	data_port_access_i,
	// Data path side
	input wire logic [12:0]	read_ptr_o,
	input wire logic	one_byte_o,
	input wire logic	swap_active_o,
	input wire logic [1:0]	mode_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// One domain for all properties
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Mode code and reset causes
	a_mode_legal: assert property (mode_o != 2'h3)
		else $error("unused mode code");
	a_pin_reset: assert property
		((!external_reset_in_n_i || voltage_fault_i) [*5] |-> mode_o == 2'h0)
		else $error("pin cause left mode");
	a_boot_reset: assert property (boot_detect_i [*5] |-> mode_o == 2'h0)
		else $error("boot cause left mode");
	// Read answers
	a_zero_in_reset: assert property
		($rose(host_data_oe_o) && mode_o == 2'h0 && $past(mode_o) == 2'h0
		|-> host_data_o == 16'h0000)
		else $error("nonzero read in reset mode");
	a_oe_after_read: assert property ($rose(host_data_oe_o) |-> $past(host_rd_n_i, 2) == 1'b0)
		else $error("data driven without read");
	// Swap, pointer and single byte
	a_cfg_gates_swap: assert property (!interface_cfg_i [*5] |-> !swap_active_o)
		else $error("swap active on byte host");
	a_ptr_steady: assert property
		((host_rd_n_i && host_wr_n_i && external_reset_in_n_i && !voltage_fault_i
		&& !boot_detect_i) [*8] |=> $stable(read_ptr_o))
		else $error("pointer moved without access");
	a_byte_clear: assert property
		(host_wr_n_i [*4] ##0 data_port_access_i |-> ##[1:2] !one_byte_o)
		else $error("single byte bit kept");
	// Main scenarios
	c_deep_power: cover property (mode_o == 2'h2);
	c_swap_on: cover property (swap_active_o);
	c_byte_clear: cover property ($fell(one_byte_o));
endmodule

bind flash_regs flash_regs_assertions flash_regs_assertions_i (.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i), .host_rd_n_i(host_rd_n_i), .host_wr_n_i(host_wr_n_i),
	.host_data_o(host_data_o), .host_data_oe_o(host_data_oe_o),
	.external_reset_in_n_i(external_reset_in_n_i), .voltage_fault_i(voltage_fault_i),
	.boot_detect_i(boot_detect_i), .interface_cfg_i(interface_cfg_i),
	.data_port_access_i(data_port_access_i), .read_ptr_o(read_ptr_o),
	.one_byte_o(one_byte_o), .swap_active_o(swap_active_o), .mode_o(mode_o));

// ---- tb/host_cpu_model.sv ----
/*
 * Host CPU on the asynchronous register bus: reads, writes, guarded
 * control sequence. Pins change on falling clock edges only.
 */
module host_cpu_model
(
	// Clock
	input wire logic	ref_clk_i,
	// Bus pins
	output logic	cs_n_o,
	output logic	rd_n_o,
	output logic	wr_n_o,
	output logic [12:0]	addr_o,
	output logic [15:0]	data_o,
	input wire logic [15:0]	data_i,
	input wire logic	oe_i
);
	timeunit 1ns;
	timeprecision 1ns;
	import flash_regs_pkg::*;

	// Idle bus at time zero
	initial
	begin
		{cs_n_o, rd_n_o, wr_n_o} = 3'h7;
		addr_o = 13'h0000;
		data_o = 16'h0000;
	end

	// Write: strobe four clocks, then hold; released lines show inverse
	task automatic write(input logic [12:0] a, input logic [15:0] d);
		@(negedge ref_clk_i);
		{addr_o, data_o, cs_n_o, wr_n_o} = {a, d, 2'h0};
		repeat (4) @(negedge ref_clk_i);
		wr_n_o = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		{addr_o, data_o, cs_n_o} = {~a, ~d, 1'b1};
		repeat (3) @(negedge ref_clk_i);
	endtask

	// Read: bounded wait for output enable, strobe held past it
	task automatic read(input logic [12:0] a, output logic [15:0] d, output logic ok);
		@(negedge ref_clk_i);
		{addr_o, cs_n_o, rd_n_o} = {a, 2'h0};
		for (int n = 0; n < 10 && oe_i !== 1'b1; n++) @(negedge ref_clk_i);
		ok = (oe_i === 1'b1);
		d = data_i;
		repeat (2) @(negedge ref_clk_i);
		rd_n_o = 1'b1;
		repeat (5) @(negedge ref_clk_i);
		{addr_o, cs_n_o} = {~a, 1'b1};
		repeat (2) @(negedge ref_clk_i);
	endtask

	// Control value then its complement, nothing between
	task automatic set_mode(input logic [7:0] v);
		write(OFS_OP_CTRL, {8'h00, v});
		write(OFS_CONFIRM, {8'h00, ~v});
	endtask
endmodule

// ---- tb/flash_disk_host_control_registers_tb.sv ----
/*
 * Self-checking bench for the flash register bank with a host model.
 * Assumes one 50 MHz clock and the bound port checker.
 */
module flash_disk_host_control_registers_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import flash_regs_pkg::*;

	localparam logic [15:0] ID_LO = 16'h3c5a; // Arbitrary value
	localparam logic [15:0] ID_HI = 16'ha5c3; // Arbitrary value

	// Bench signals
	logic	clk = 1'b0;
	logic	rst_n = 1'b0;
	logic	cs_n, rd_n, wr_n, oe, one_byte, swap_on;
	logic	ext_n = 1'b1, vfault = 1'b0, boot = 1'b0, cfg = 1'b0, dpa = 1'b0;
	logic	clk_en = 1'b1;
	logic [12:0]	addr, ptr;
	logic [15:0]	wdata, rdata;
	logic [1:0]	mode;
	int	error_cnt = 0;
	int	samples_checked = 0;

	// Clock
	always #10 clk = ~clk;

	flash_regs #(.IDENT_LOW_VAL(ID_LO), .IDENT_HIGH_VAL(ID_HI)) flash_regs_i (
		.ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(clk_en), .host_cs_n_i(cs_n),
		.host_rd_n_i(rd_n), .host_wr_n_i(wr_n), .host_addr_i(addr),
		.host_data_i(wdata), .host_data_o(rdata), .host_data_oe_o(oe),
		.external_reset_in_n_i(ext_n), .voltage_fault_i(vfault), .boot_detect_i(boot),
		.interface_cfg_i(cfg), .data_port_access_i(dpa), .read_ptr_o(ptr),
		.one_byte_o(one_byte), .swap_active_o(swap_on), .mode_o(mode));

	host_cpu_model host_cpu_model_i (.ref_clk_i(clk), .cs_n_o(cs_n), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .addr_o(addr), .data_o(wdata), .data_i(rdata), .oe_i(oe));

	// Shared compare, read and write helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		if (got !== exp)
			error_cnt++;
	endtask
	task automatic rchk(input logic [12:0] a, input logic [15:0] e);
		logic [15:0] d;
		logic ok;
		host_cpu_model_i.read(a, d, ok);
		chk({15'h0, ok}, 16'h0001);
		if (!ok)
			end_sim();
		chk(d, e);
	endtask
	task automatic wr(input logic [12:0] a, input logic [15:0] d);
		host_cpu_model_i.write(a, d);
	endtask

	// Reset mode reads zero, leave it, identity, scratch, frozen clock
	task automatic t_basic();
		rchk(OFS_IDENT_LOW, READ_ZERO);
		host_cpu_model_i.set_mode(8'h05);
		chk({14'h0, mode}, 16'h0001);
		rchk(OFS_OP_CTRL, 16'h0011);
		rchk(OFS_IDENT_LOW, ID_LO);
		rchk(OFS_IDENT_HIGH, ID_HI);
		rchk(OFS_IDENT_HIGH, ID_HI);
		rchk(OFS_SCRATCH, 16'h0000);
		wr(OFS_SCRATCH, 16'h00a5);
		wr(OFS_NOP, 16'h005a);
		// A whole write while the enable is low must leave no trace
		clk_en = 1'b0;
		wr(OFS_SCRATCH, 16'h00ff);
		clk_en = 1'b1;
		rchk(OFS_SCRATCH, 16'h00a5);
		rchk(OFS_CONFIRM, READ_ZERO);
		rchk(OFS_NOP, READ_ZERO);
		$display("done basic");
	endtask

	// Mode table, broken, interrupted and boot block sequences
	task automatic t_modes();
		logic [7:0] v [5] = '{8'h02, 8'h06, 8'h07, 8'h05, 8'h15};
		logic [1:0] m [5] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h1};
		for (int i = 0; i < 5; i++)
		begin
			host_cpu_model_i.set_mode(v[i]);
			chk({14'h0, mode}, {14'h0, m[i]});
		end
		rchk(OFS_OP_CTRL, 16'h0001);
		wr(OFS_OP_CTRL, 16'h0006);
		wr(OFS_CONFIRM, 16'h0000);
		chk({14'h0, mode}, 16'h0001);
		wr(OFS_OP_CTRL, 16'h0006);
		rchk(OFS_SCRATCH, 16'h00a5);
		wr(OFS_CONFIRM, 16'h00f9);
		chk({14'h0, mode}, 16'h0001);
		// A boot block read between the two writes keeps the pending value
		wr(OFS_OP_CTRL, 16'h0006);
		rchk(BOOT_HIGH_START, READ_ZERO);
		wr(OFS_CONFIRM, 16'h00f9);
		chk({14'h0, mode}, 16'h0002);
		host_cpu_model_i.set_mode(8'h05);
		chk({14'h0, mode}, 16'h0001);
		$display("done modes");
	endtask

	// Pointer steps by byte and word, hold, single byte clear
	task automatic t_pointer();
		wr(OFS_READ_PTR, 16'h9004);
		rchk(OFS_SCRATCH, 16'h00a5);
		chk({3'h0, ptr}, 16'h1005);
		cfg = 1'b1;
		wr(OFS_READ_PTR, 16'h9000);
		rchk(OFS_SCRATCH, 16'h00a5);
		chk({3'h0, ptr}, 16'h1002);
		wr(OFS_READ_PTR, 16'h5004);
		rchk(OFS_SCRATCH, 16'h00a5);
		chk({3'h0, ptr}, 16'h1004);
		chk({15'h0, one_byte}, 16'h0001);
		dpa = 1'b1;
		@(negedge clk);
		dpa = 1'b0;
		repeat (2) @(negedge clk);
		chk({15'h0, one_byte}, 16'h0000);
		$display("done pointer");
	endtask

	// Swap with both bits set, active only on a word host
	task automatic t_swap();
		wr(OFS_SWAP_CTRL, 16'h0101);
		chk({15'h0, swap_on}, 16'h0001);
		wr(OFS_SCRATCH, 16'h3c00);
		rchk(OFS_SCRATCH, 16'h3c00);
		cfg = 1'b0;
		repeat (4) @(negedge clk);
		chk({15'h0, swap_on}, 16'h0000);
		rchk(OFS_SCRATCH, 16'h003c);
		wr(OFS_SWAP_CTRL, 16'h0000);
		$display("done swap");
	endtask

	// Boot, voltage and pin causes with their flags
	task automatic t_causes();
		for (int k = 0; k < 3; k++)
		begin
			{boot, vfault, ext_n} = (k == 0) ? 3'h5 : (k == 1) ? 3'h3 : 3'h0;
			repeat (6) @(negedge clk);
			{boot, vfault, ext_n} = 3'h1;
			repeat (4) @(negedge clk);
			chk({14'h0, mode}, 16'h0000);
			rchk(OFS_IDENT_HIGH, READ_ZERO);
			host_cpu_model_i.set_mode(8'h05);
			rchk(OFS_OP_CTRL, (k == 0) ? 16'h0009 : 16'h0011);
			host_cpu_model_i.set_mode(8'h1d);
			rchk(OFS_OP_CTRL, 16'h0001);
		end
		// Software entry to reset mode sets no cause flag
		host_cpu_model_i.set_mode(8'h04);
		chk({14'h0, mode}, 16'h0000);
		rchk(OFS_OP_CTRL, READ_ZERO);
		host_cpu_model_i.set_mode(8'h05);
		rchk(OFS_OP_CTRL, 16'h0001);
		$display("done causes");
	endtask

	// Verdict
	task automatic end_sim();
		$display("compares %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_basic();
		t_modes();
		t_pointer();
		t_swap();
		t_causes();
		end_sim();
	end
endmodule
